// ===== src/dimap_pkg.sv
// constants and types shared by the digital input function mapper
package dimap_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int DIMAP_NIN    = 8;
    localparam int DIMAP_CODE_W = 8;
    localparam int DIMAP_NFUNC  = 33;
    localparam int DIMAP_ADDR_W = 5;
    localparam int DIMAP_DATA_W = 32;

    // ------------------------------------------------------------------
    // function indices into the decoded function vector
    // ------------------------------------------------------------------
    localparam int FN_RUN       = 0;
    localparam int FN_ALM_CLR   = 1;
    localparam int FN_GAIN      = 2;
    localparam int FN_PCLR      = 3;
    localparam int FN_ZCLAMP    = 4;
    localparam int FN_CMD_REV   = 5;
    localparam int FN_TRIG      = 6;
    localparam int FN_TQ_CMD    = 7;
    localparam int FN_SP_CMD    = 8;
    localparam int FN_POSITION_SEL_BIT0      = 9;
    localparam int FN_SPD0      = 12;
    localparam int FN_TCM0      = 14;
    localparam int FN_SW_SP     = 16;
    localparam int FN_SW_ST     = 17;
    localparam int FN_SW_TP     = 18;
    localparam int FN_OPSTOP    = 19;
    localparam int FN_REV_LIM   = 20;
    localparam int FN_FWD_LIM   = 21;
    localparam int FN_HOME_SENS = 22;
    localparam int FN_REV_TQ    = 23;
    localparam int FN_FWD_TQ    = 24;
    localparam int FN_HOME_MOVE = 25;
    localparam int FN_PULSE_INTERNAL_SWITCH     = 26;
    localparam int FN_JOG_F     = 27;
    localparam int FN_JOG_R     = 28;
    localparam int FN_GEAR0     = 29;
    localparam int FN_INHIBIT   = 31;
    localparam int FN_STOP      = 32;

    // function code per index; 0x07 and anything absent decode to nothing
    localparam logic [7:0] DIMAP_CODE_TABLE [DIMAP_NFUNC] = '{
        8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09,
        8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17,
        8'h18, 8'h19, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
        8'h26, 8'h27, 8'h2a, 8'h37, 8'h38, 8'h43, 8'h44, 8'h45,
        8'h46};

    // ------------------------------------------------------------------
    // register map (word index on the register port)
    // ------------------------------------------------------------------
    localparam logic [4:0] REG_SEL_BASE = 5'h00;
    localparam logic [4:0] REG_CTRL     = 5'h08;
    localparam logic [4:0] REG_JOG      = 5'h09;
    localparam logic [4:0] REG_FUNC_LO  = 5'h0a;
    localparam logic [4:0] REG_FUNC_HI  = 5'h0b;
    localparam logic [4:0] REG_STATUS   = 5'h0c;
    localparam logic [4:0] REG_LEVEL    = 5'h0d;

    // control register fields
    localparam int CTRL_TQ_EN_BIT = 0;
    localparam int CTRL_MODE_LSB  = 4;
    localparam int CTRL_MODE_W    = 4;
    localparam int JOG_W          = 16;

    // reset values: run enable on input 1, alarm clear on input 5
    localparam logic [7:0][7:0] SEL_RESET = {
        8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01};
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [15:0] JOG_RESET  = 16'h0014;

    // ------------------------------------------------------------------
    // control modes and resolved loop
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_PT, MODE_PR, MODE_S, MODE_T, MODE_SZ, MODE_TZ,
        MODE_PT_S, MODE_PT_T, MODE_PR_S, MODE_PR_T, MODE_S_T,
        MODE_PULSE_INTERNAL_SWITCH, MODE_FIELDBUS
    } dimap_mode_type;

    typedef enum logic [1:0] {
        LOOP_PULSE, LOOP_INTPOS, LOOP_SPEED, LOOP_TORQUE
    } dimap_loop_type;

endpackage : dimap_pkg

// ===== src/dimap_map_if.sv
// carrier between the register side and the function decoder
`timescale 1ns/1ps
`default_nettype none
interface dimap_map_if;
    logic [7:0][7:0]                    sel;
    logic [7:0]                         level;
    logic [dimap_pkg::DIMAP_NFUNC-1:0]  on;
    logic [dimap_pkg::DIMAP_NFUNC-1:0]  bound;

    modport ctl (output sel, output level, input on, input bound);
    modport dec (input sel, input level, output on, output bound);
endinterface : dimap_map_if
`default_nettype wire

// ===== src/dimap_decode.sv
// function decoder: one hit per input and function code
`timescale 1ns/1ps
`default_nettype none
module dimap_decode
(
    // decoder side of the carrier
    dimap_map_if.dec m
);

    localparam int NI = dimap_pkg::DIMAP_NIN;
    localparam int NF = dimap_pkg::DIMAP_NFUNC;

    logic [NF-1:0][NI-1:0] hit;
    logic [NF-1:0][NI-1:0] match;

    // ------------------------------------------------------------------
    // match every input against every known code
    // ------------------------------------------------------------------
    genvar f, j;
    generate
        for (f = 0; f < NF; f++)
        begin : g_func
            for (j = 0; j < NI; j++)
            begin : g_in
                // unknown or reserved codes match no entry at all
                assign match[f][j] =
                    (m.sel[j] == dimap_pkg::DIMAP_CODE_TABLE[f]);
                assign hit[f][j] = match[f][j] && m.level[j];
            end
            // a function bound to no input stays off
            assign m.on[f]    = |hit[f];
            assign m.bound[f] = |match[f];
        end
    endgenerate

endmodule : dimap_decode
`default_nettype wire

// ===== src/dimap_top.sv
// digital input function mapper: settings, decode, mode and alarms
`timescale 1ns/1ps
`default_nettype none

module dimap_top
(
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    // register port
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // digital input levels, one per input
    input  wire logic [7:0]  din_i,
    // decoded commands and jog speed setting
    output logic             run_enable_o,
    output logic             alarm_clear_o,
    output logic             gain_switch_o,
    output logic             pulse_clear_o,
    output logic             zero_clamp_o,
    output logic             cmd_invert_o,
    output logic             cmd_trigger_o,
    output logic             torque_limit_cmd_o,
    output logic             speed_limit_cmd_o,
    output logic [2:0]       position_index_o,
    output logic [1:0]       speed_index_o,
    output logic [1:0]       torque_index_o,
    output logic [1:0]       gear_index_o,
    output logic             rev_torque_limit_o,
    output logic             fwd_torque_limit_o,
    output logic             home_move_o,
    output logic             home_sensor_o,
    output logic             jog_fwd_o,
    output logic             jog_rev_o,
    output logic [15:0]      jog_speed_o,
    output logic             pulse_inhibit_o,
    output logic             motor_stop_o,
    output logic [1:0]       active_loop_o,
    // alarms
    output logic             stop_alarm_o,
    output logic             rev_limit_alarm_o,
    output logic             fwd_limit_alarm_o
);

    localparam int NF = dimap_pkg::DIMAP_NFUNC;
    localparam int OW = 29;

    dimap_map_if m ();

    logic [7:0][7:0]              sel_q;
    logic [31:0]                  ctrl_q;
    logic [15:0]                  jog_q;
    logic [31:0]                  rdata_q;
    logic [31:0]                  rdata_d;
    logic [OW-1:0]                out_q;
    logic [OW-1:0]                out_d;
    logic [2:0]                   alarm_q;
    logic [2:0]                   alarm_set;
    logic [NF-1:0]                fn;
    dimap_pkg::dimap_mode_type    mode;
    dimap_pkg::dimap_loop_type    loop_d;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire       wr_sel  = reg_wr_i && (reg_addr_i[4:3] == 2'b00);
    wire [2:0] sel_idx = reg_addr_i[2:0];
    wire       wr_ctrl = reg_wr_i && (reg_addr_i == dimap_pkg::REG_CTRL);
    wire       wr_jog  = reg_wr_i && (reg_addr_i == dimap_pkg::REG_JOG);
    wire       tq_en   = ctrl_q[dimap_pkg::CTRL_TQ_EN_BIT];
    wire       fbus    = (mode == dimap_pkg::MODE_FIELDBUS);
    wire       intpos  = (loop_d == dimap_pkg::LOOP_INTPOS);
    wire       extpls  = (loop_d == dimap_pkg::LOOP_PULSE);

    assign mode = dimap_pkg::dimap_mode_type'(
        ctrl_q[dimap_pkg::CTRL_MODE_LSB +: dimap_pkg::CTRL_MODE_W]);

    // ------------------------------------------------------------------
    // per-input function settings
    // ------------------------------------------------------------------
    genvar k;
    generate
        for (k = 0; k < dimap_pkg::DIMAP_NIN; k++)
        begin : g_sel
            always_ff @(posedge core_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                    sel_q[k] <= dimap_pkg::SEL_RESET[k];
                else if (wr_sel && (sel_idx == 3'(k)))
                    sel_q[k] <= reg_wdata_i[7:0];
            end
        end
    endgenerate

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl_q <= dimap_pkg::CTRL_RESET;
            jog_q  <= dimap_pkg::JOG_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_q <= reg_wdata_i & 32'h0000_00f1;
            if (wr_jog)
                jog_q <= reg_wdata_i[15:0];
        end
    end

    // ------------------------------------------------------------------
    // decoder
    // ------------------------------------------------------------------
    assign m.sel   = sel_q;
    assign m.level = din_i;
    assign fn      = m.on;

    dimap_decode u_dec (
        .m (m.dec)
    );

    // ------------------------------------------------------------------
    // resolved control loop
    // ------------------------------------------------------------------
    always_comb
    begin
        case (mode)
            dimap_pkg::MODE_PT:   loop_d = dimap_pkg::LOOP_PULSE;
            dimap_pkg::MODE_PR:   loop_d = dimap_pkg::LOOP_INTPOS;
            dimap_pkg::MODE_S,
            dimap_pkg::MODE_SZ:   loop_d = dimap_pkg::LOOP_SPEED;
            dimap_pkg::MODE_T,
            dimap_pkg::MODE_TZ:   loop_d = dimap_pkg::LOOP_TORQUE;
            dimap_pkg::MODE_PT_S:
                loop_d = fn[dimap_pkg::FN_SW_SP] ? dimap_pkg::LOOP_PULSE
                                                 : dimap_pkg::LOOP_SPEED;
            dimap_pkg::MODE_PR_S:
                loop_d = fn[dimap_pkg::FN_SW_SP] ? dimap_pkg::LOOP_INTPOS
                                                 : dimap_pkg::LOOP_SPEED;
            dimap_pkg::MODE_PT_T:
                loop_d = fn[dimap_pkg::FN_SW_TP] ? dimap_pkg::LOOP_PULSE
                                                 : dimap_pkg::LOOP_TORQUE;
            dimap_pkg::MODE_PR_T:
                loop_d = fn[dimap_pkg::FN_SW_TP] ? dimap_pkg::LOOP_INTPOS
                                                 : dimap_pkg::LOOP_TORQUE;
            dimap_pkg::MODE_S_T:
                loop_d = fn[dimap_pkg::FN_SW_ST] ? dimap_pkg::LOOP_TORQUE
                                                 : dimap_pkg::LOOP_SPEED;
            dimap_pkg::MODE_PULSE_INTERNAL_SWITCH:
                loop_d = fn[dimap_pkg::FN_PULSE_INTERNAL_SWITCH] ? dimap_pkg::LOOP_INTPOS
                                                 : dimap_pkg::LOOP_PULSE;
            dimap_pkg::MODE_FIELDBUS: loop_d = dimap_pkg::LOOP_INTPOS;
            default:              loop_d = dimap_pkg::LOOP_PULSE;
        endcase
    end

    // ------------------------------------------------------------------
    // command outputs, registered one cycle after the inputs
    // ------------------------------------------------------------------
    // opposing jog requests cancel so the motor never gets both
    wire jog_f = fn[dimap_pkg::FN_JOG_F] && !fn[dimap_pkg::FN_JOG_R];
    wire jog_r = fn[dimap_pkg::FN_JOG_R] && !fn[dimap_pkg::FN_JOG_F];

    assign out_d = {
        loop_d,                                          // 28:27
        fn[dimap_pkg::FN_STOP],                          // 26
        fn[dimap_pkg::FN_INHIBIT] && extpls,             // 25
        jog_r && !fbus,                                  // 24
        jog_f && !fbus,                                  // 23
        fn[dimap_pkg::FN_HOME_SENS],                     // 22
        fn[dimap_pkg::FN_HOME_MOVE] && intpos,           // 21
        fn[dimap_pkg::FN_FWD_TQ] && tq_en,               // 20
        fn[dimap_pkg::FN_REV_TQ] && tq_en,               // 19
        fn[dimap_pkg::FN_GEAR0 +: 2],                    // 18:17
        fn[dimap_pkg::FN_TCM0 +: 2],                     // 16:15
        fn[dimap_pkg::FN_SPD0 +: 2],                     // 14:13
        fn[dimap_pkg::FN_POSITION_SEL_BIT0 +: 3],                     // 12:10
        fn[dimap_pkg::FN_SP_CMD],                        // 9
        fn[dimap_pkg::FN_TQ_CMD],                        // 8
        fn[dimap_pkg::FN_TRIG],                          // 7
        fn[dimap_pkg::FN_CMD_REV],                       // 6
        fn[dimap_pkg::FN_ZCLAMP],                        // 5
        fn[dimap_pkg::FN_PCLR],                          // 4
        fn[dimap_pkg::FN_GAIN],                          // 3
        fn[dimap_pkg::FN_ALM_CLR],                       // 2
        fn[dimap_pkg::FN_RUN],                           // 1
        1'b0                                             // 0
    };

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            out_q <= '0;
        else
            out_q <= out_d;
    end

    assign {active_loop_o, motor_stop_o, pulse_inhibit_o, jog_rev_o,
            jog_fwd_o, home_sensor_o, home_move_o, fwd_torque_limit_o,
            rev_torque_limit_o, gear_index_o, torque_index_o,
            speed_index_o, position_index_o, speed_limit_cmd_o,
            torque_limit_cmd_o, cmd_trigger_o, cmd_invert_o, zero_clamp_o,
            pulse_clear_o, gain_switch_o, alarm_clear_o,
            run_enable_o} = out_q[28:1];
    assign jog_speed_o = jog_q;

    // ------------------------------------------------------------------
    // normally closed inputs: sticky alarms, set wins over clear
    // ------------------------------------------------------------------
    // an unassigned limit or stop is not wired, so it cannot alarm
    assign alarm_set[0] = m.bound[dimap_pkg::FN_OPSTOP]
                          && !fn[dimap_pkg::FN_OPSTOP];
    assign alarm_set[1] = m.bound[dimap_pkg::FN_REV_LIM]
                          && !fn[dimap_pkg::FN_REV_LIM];
    assign alarm_set[2] = m.bound[dimap_pkg::FN_FWD_LIM]
                          && !fn[dimap_pkg::FN_FWD_LIM];

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            alarm_q <= '0;
        else if (fn[dimap_pkg::FN_ALM_CLR])
            alarm_q <= alarm_set;
        else
            alarm_q <= alarm_q | alarm_set;
    end

    assign stop_alarm_o      = alarm_q[0];
    assign rev_limit_alarm_o = alarm_q[1];
    assign fwd_limit_alarm_o = alarm_q[2];

    // ------------------------------------------------------------------
    // read back: data valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    always_comb
    begin
        rdata_d = '0;
        if (reg_rd_i)
        begin
            if (reg_addr_i[4:3] == 2'b00)
                rdata_d = {24'h00_0000, sel_q[sel_idx]};
            else if (reg_addr_i == dimap_pkg::REG_CTRL)
                rdata_d = ctrl_q;
            else if (reg_addr_i == dimap_pkg::REG_JOG)
                rdata_d = {16'h0000, jog_q};
            else if (reg_addr_i == dimap_pkg::REG_FUNC_LO)
                rdata_d = fn[31:0];
            else if (reg_addr_i == dimap_pkg::REG_FUNC_HI)
                rdata_d = {31'h0000_0000, fn[NF-1]};
            else if (reg_addr_i == dimap_pkg::REG_STATUS)
                rdata_d = {27'h000_0000, alarm_q, out_q[28:27]};
            else if (reg_addr_i == dimap_pkg::REG_LEVEL)
                rdata_d = {24'h00_0000, din_i};
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    a_torque_limit_gate:
        assert property ((fn[dimap_pkg::FN_REV_TQ] && !tq_en)
                         |=> !rev_torque_limit_o)
        else $error("reverse torque limit passed while disabled");
    a_home_move_cmd:
        assert property ((fn[dimap_pkg::FN_HOME_MOVE] && intpos)
                         |=> home_move_o)
        else $error("home move not commanded in internal position");
    a_jog_fwd_bus:
        assert property (fbus |=> !jog_fwd_o)
        else $error("forward jog in fieldbus mode");
    a_jog_rev_cmd:
        assert property ((jog_r && !fbus) |=> jog_rev_o && !jog_fwd_o)
        else $error("reverse jog not commanded");
    a_gear_index_pick:
        assert property (1'b1 |=> gear_index_o
                         == $past(fn[dimap_pkg::FN_GEAR0 +: 2]))
        else $error("gear index does not follow select inputs");
    a_pulse_inhibit_gate:
        assert property (pulse_inhibit_o |-> $past(extpls))
        else $error("pulse inhibit outside external pulse mode");
    a_unbound_func_idle:
        assert property ((fn & ~m.bound) == '0)
        else $error("unassigned function active");
    a_sel_write_store:
        assert property (wr_sel |=> sel_q[$past(sel_idx)]
                         == $past(reg_wdata_i[7:0]))
        else $error("function setting not stored");
    a_speed_pos_switch:
        assert property ((mode == dimap_pkg::MODE_PT_S
                          && !fn[dimap_pkg::FN_SW_SP])
                         |=> active_loop_o == dimap_pkg::LOOP_SPEED)
        else $error("speed not selected with switch low");
    a_cmd_reverse_follow:
        assert property (fn[dimap_pkg::FN_CMD_REV] |=> cmd_invert_o)
        else $error("command reverse not applied");
    a_rev_limit_alarm:
        assert property (alarm_set[1] |=> rev_limit_alarm_o)
        else $error("reverse limit alarm missing");
    a_stop_alarm_raise:
        assert property (alarm_set[0] |=> stop_alarm_o)
        else $error("stop alarm missing");

endmodule : dimap_top
`default_nettype wire

// ===== testbench/dimap_din_drv.sv
// partner model: controller or switches driving the digital inputs
`timescale 1ns/1ps
`default_nettype none
module dimap_din_drv
(
    // clock
    input  wire logic       core_clk_i,
    // wanted switch levels
    input  wire logic [7:0] want_i,
    // levels at the input pins
    output var  logic [7:0] din_o
);
    initial din_o = 8'h00;
    // stop and limit contacts follow the wanted levels like every other input
    always @(posedge core_clk_i)
    begin
        din_o <= want_i;
    end
endmodule : dimap_din_drv
`default_nettype wire

// ===== testbench/dimap_top_tb.sv
// self-checking bench for the digital input function mapper
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    bad_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module dimap_top_tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [4:0]  addr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  want = 8'h00;
    logic [7:0]  din;
    logic [31:0] rdo;
    logic [31:0] rv;
    logic [32:0] fv;
    logic [32:0] ev;
    logic        run, aclr, rtq, home, jf, inh, ralm;
    logic        gain, pclr, zcl, inv, trig, tqlm, splm, ftq, hsen;
    logic        jr, stp, salm, falm;
    logic [2:0]  pidx;
    logic [1:0]  sidx, tidx, gidx, loop;
    logic [25:0] eo;
    logic [15:0] jspd;
    int          bad_count = 0;
    int          n_compared = 0;
    // one row per code on input 2 except 0x21-0x23 and 0x2a: function bit and command output bit
    logic [7:0]  row_code [31] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
        8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12, 8'h13,
        8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h20, 8'h24, 8'h25,
        8'h26, 8'h27, 8'h37, 8'h38, 8'h43, 8'h44, 8'h45, 8'h46};
    int          row_bit [31] = '{-1, 0, 1, 2, 3, 4, 5, -1, 6, 7, 8, 9,
        10, 11, 12, 13, 14, 15, 16, 17, 18, 22, 23, 24, 25, 27, 28, 29,
        30, 31, 32};
    // pulse mode, torque limit off: 0x18-0x20 and 0x25-0x27 give no command
    int          row_obit [31] = '{-1, 0, 1, 2, 3, 4, 5, -1, 6, 7, 8, 9,
        10, 11, 12, 13, 14, 15, -1, -1, -1, 21, -1, -1, -1, 22, 23, 16,
        17, 24, 25};
    wire  [25:0] ov = {stp, inh, jr, jf, hsen, home, ftq, rtq, gidx, tidx,
        sidx, pidx, splm, tqlm, trig, inv, zcl, pclr, gain, aclr, run};

    always #20 clk = ~clk;

    dimap_din_drv u_dimap_din_drv (.core_clk_i(clk), .want_i(want),
        .din_o(din));
    dimap_top u_dimap_top (.core_clk_i(clk), .nrst_i(nrst),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdo), .din_i(din),
        .run_enable_o(run), .alarm_clear_o(aclr), .gain_switch_o(gain),
        .pulse_clear_o(pclr), .zero_clamp_o(zcl), .cmd_invert_o(inv),
        .cmd_trigger_o(trig), .torque_limit_cmd_o(tqlm),
        .speed_limit_cmd_o(splm), .position_index_o(pidx),
        .speed_index_o(sidx), .torque_index_o(tidx),
        .gear_index_o(gidx), .rev_torque_limit_o(rtq),
        .fwd_torque_limit_o(ftq), .home_move_o(home),
        .home_sensor_o(hsen), .jog_fwd_o(jf), .jog_rev_o(jr),
        .jog_speed_o(jspd), .pulse_inhibit_o(inh), .motor_stop_o(stp),
        .active_loop_o(loop), .stop_alarm_o(salm),
        .rev_limit_alarm_o(ralm), .fwd_limit_alarm_o(falm));

    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdo;
    endtask : rd_reg

    task automatic step(input logic [7:0] w);
        @(posedge clk);
        want <= w;
        repeat (4) @(posedge clk);
        #1;
    endtask : step

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 31; i++)
        begin
            wr_reg(5'h01, {24'h0, row_code[i]});
            step(8'h02);
            rd_reg(dimap_pkg::REG_FUNC_LO, rv);
            fv[31:0] = rv;
            rd_reg(dimap_pkg::REG_FUNC_HI, rv);
            fv[32] = rv[0];
            ev = (row_bit[i] < 0) ? 33'h0 : (33'h1 << row_bit[i]);
            `CHK("func_vec", ev, fv)
            eo = (row_obit[i] < 0) ? 26'h0 : (26'h1 << row_obit[i]);
            `CHK("out_vec", eo, ov)
        end
        $display("code table done");
        wr_reg(dimap_pkg::REG_JOG, 32'h0000_1234);
        step(8'h11);
        `CHK("jog_speed_set", 16'h1234, jspd)
        @(posedge clk);
        nrst <= 1'b0;
        step(8'h11);
        `CHK("jog_speed", 16'h0014, jspd)
        `CHK("run_in_reset", 1'b0, run)
        @(posedge clk);
        nrst <= 1'b1;
        step(8'h11);
        `CHK("run_enable", 1'b1, run)
        `CHK("alarm_clear", 1'b1, aclr)
        wr_reg(5'h02, 32'h25);
        step(8'h04);
        `CHK("rev_tq_off", 1'b0, rtq)
        wr_reg(dimap_pkg::REG_CTRL, 32'h1);
        step(8'h04);
        `CHK("rev_tq_on", 1'b1, rtq)
        wr_reg(5'h02, 32'h26);
        step(8'h04);
        `CHK("fwd_tq_on", 1'b1, ftq)
        wr_reg(5'h02, 32'h27);
        wr_reg(dimap_pkg::REG_CTRL, 32'h10);
        step(8'h04);
        `CHK("home_pr", 1'b1, home)
        wr_reg(5'h02, 32'h37);
        wr_reg(dimap_pkg::REG_CTRL, 32'hc0);
        step(8'h04);
        `CHK("jog_bus", 1'b0, jf)
        wr_reg(5'h02, 32'h38);
        step(8'h04);
        `CHK("jog_rev_bus", 1'b0, jr)
        wr_reg(5'h02, 32'h45);
        wr_reg(dimap_pkg::REG_CTRL, 32'h0);
        step(8'h04);
        `CHK("inhibit", 1'b1, inh)
        wr_reg(dimap_pkg::REG_CTRL, 32'h10);
        step(8'h04);
        `CHK("inhibit_pr", 1'b0, inh)
        wr_reg(5'h02, 32'h2a);
        wr_reg(dimap_pkg::REG_CTRL, 32'hb0);
        step(8'h04);
        `CHK("loop_intpos", 2'h1, loop)
        step(8'h00);
        `CHK("loop_pulse", 2'h0, loop)
        wr_reg(5'h02, 32'h19);
        wr_reg(dimap_pkg::REG_CTRL, 32'ha0);
        step(8'h04);
        `CHK("loop_torque", 2'h3, loop)
        // binding the contact while it is open trips at once; clear it
        wr_reg(5'h03, 32'h22);
        step(8'h1c);
        `CHK("limit_held", 1'b0, ralm)
        step(8'h04);
        `CHK("limit_trip", 1'b1, ralm)
        wr_reg(5'h05, 32'h21);
        wr_reg(5'h06, 32'h23);
        step(8'h00);
        `CHK("stop_trip", 1'b1, salm)
        `CHK("fwd_trip", 1'b1, falm)
        step(8'h10);
        `CHK("stop_kept", 1'b1, salm)
        rd_reg(dimap_pkg::REG_STATUS, rv);
        `CHK("status", 32'h0000_001e, rv)
        rd_reg(5'h1f, rv);
        `CHK("unmapped", 32'h0, rv)
        $display("hand tests done");
        end_of_test();
    end
endmodule : dimap_top_tb
`default_nettype wire
